// ### verilog/memclk_consts.vh
/*
 * Constants for the memory interface clock output block: register offsets,
 * field positions, encodings and reset values.
 * Assumes it is included by bare name from the design files.
 */
`ifndef MEMCLK_CONSTS_VH
`define MEMCLK_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MEMCLK_ADDR_W           4
`define MEMCLK_DATA_W           16
`define OFS_GLOBAL_CONTROL_ONE  4'h0
`define OFS_GLOBAL_CONTROL_TWO  4'h1
`define OFS_CLOCK_STATUS        4'h2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTL1_MODE_LSB           0
`define CTL1_HOLD_TRI_BIT       2
`define CTL2_FACTOR_LSB         0
`define CTL2_MODE_LSB           2
`define CTL2_HOLD_TRI_BIT       4
`define STAT_SOURCE_BIT         0
`define STAT_STRAP_BIT          1
`define STAT_HOLD_BIT           2
`define STAT_OFF_BIT            3
`define STAT_ACK_BIT            4
`define STAT_PRI_OE_BIT         5
`define STAT_DIV_OE_BIT         6

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define MODE_RUN                2'h0
`define MODE_LOW                2'h1
`define MODE_HIZ                2'h2
`define FACTOR_DIV1             2'h0
`define FACTOR_DIV2             2'h1
`define FACTOR_DIV4             2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define HOLD_TRI_RESET          1'h0
`define RDATA_RESET             16'h0000

`endif

// ### verilog/clock_gate_divider.v
/*
 * Divides a sampled clock level by 1, 2 or 4 and gates it low or off.
 * Assumes i_src_level is already synchronised to i_clk. Factor and mode
 * requests are adopted while every divided phase is low, and in the first reset cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "memclk_consts.vh"

module clock_gate_divider (
    input  wire       i_clk,
    input  wire       i_resetn,
    input  wire       i_src_level,
    input  wire [1:0] i_factor,
    input  wire [1:0] i_mode,
    output reg        o_clk,
    output reg        o_oe
);
    reg       src_prev;
    reg       in_reset;
    reg [1:0] count;
    reg [1:0] factor;
    reg [1:0] mode;
    wire      rise;
    wire      fall;

    assign rise = i_src_level & ~src_prev;
    assign fall = ~i_src_level & src_prev;

    // ------------------------------------------------------------------
    // Divider state
    // ------------------------------------------------------------------
    // The divider keeps running through reset; only the first reset
    // cycle clears it, so the output can toggle while reset is held.
    always @(posedge i_clk) begin
        src_prev <= i_src_level;
        in_reset <= ~i_resetn;
        if (i_resetn || in_reset) begin
            if (rise)
                count <= count + 2'h1;
            // Falling edge with count zero: every phase is low here
            if (fall && count == 2'h0) begin
                factor <= i_factor;
                mode   <= i_mode;
            end
        end else begin
            count  <= 2'h0;
            factor <= i_factor;
            mode   <= i_mode;
        end
    end

    // ------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------
    always @(posedge i_clk) begin
        o_oe <= (mode == `MODE_RUN) || (mode == `MODE_LOW);
        if (mode != `MODE_RUN)
            o_clk <= 1'b0;
        else if (factor == `FACTOR_DIV1)
            o_clk <= i_src_level;
        else if (factor == `FACTOR_DIV2)
            o_clk <= count[0];
        else
            o_clk <= count[1];
    end
endmodule

`default_nettype wire

// ### verilog/memclk_outputs.v
/*
 * Memory interface clock outputs: source selection, primary and divided
 * memory clock outputs, boot strap capture and bus-hold acknowledge.
 * Assumes both clock sources and all pins are slow against i_clk, so that
 * sampling them gives their level; register port is a plain strobe port.
 */
// How it works
// - Source select low picks internal, high external clock; primary uses external until the first control one write
// - Primary forwards clock, or low, or off
// - Primary is off while reset is held
// - After reset primary off for straps 0,0
// - Divided output runs at clock over 1, 2, 4
// - Divided output can be forced low or off
// - Divided output runs at quarter rate in reset
// - After reset divided output set by both straps
// - Hold tristate clear keeps output clocking in hold
// - Hold tristate set turns output off in hold
// - Both outputs off in emulation off mode
// - Strap high in reset enables memory pin function
// - Acknowledge hold in the same cycle tristating outputs go off
`timescale 1ns/1ps
`default_nettype none
`include "memclk_consts.vh"

module memclk_outputs (
    input  wire                        i_clk,
    input  wire                        i_resetn,
    input  wire                        i_ext_mem_clock_in,
    input  wire                        i_internal_system_clock_three,
    input  wire                        i_mem_clock_source_select,
    input  wire                        i_boot_function_strap,
    input  wire                        i_bus_hold_request,
    input  wire                        i_test_resetn,
    input  wire                        i_emulation_pin_zero,
    input  wire                        i_emulation_pin_one_off,
    input  wire [`MEMCLK_ADDR_W-1:0]   i_addr,
    input  wire [`MEMCLK_DATA_W-1:0]   i_wdata,
    input  wire                        i_wstrobe,
    input  wire                        i_rstrobe,
    output reg  [`MEMCLK_DATA_W-1:0]   o_rdata,
    output reg                         o_mem_clock_out_primary,
    output reg                         o_mem_clock_out_primary_oe,
    output reg                         o_mem_clock_out_divided,
    output reg                         o_mem_clock_out_divided_oe,
    output reg                         o_bus_hold_acknowledge,
    output reg                         o_bus_hold_acknowledge_oe,
    output reg                         o_mem_function_enable
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Bit order: ext clk, int clk, source select, strap, hold, trst, emulation_pin_zero,
    // emu1. Stage one feeds stage two only.
    reg  [7:0] sync_one;
    reg  [7:0] sync_two;
    wire       ext_level;
    wire       int_level;
    wire       sel_level;
    wire       strap_level;
    wire       hold_level;
    wire       trst_level;
    wire       emulation_pin_zero_level;
    wire       emu1_level;

    always @(posedge i_clk) begin
        sync_one <= {i_emulation_pin_one_off, i_emulation_pin_zero, i_test_resetn,
                     i_bus_hold_request, i_boot_function_strap,
                     i_mem_clock_source_select, i_internal_system_clock_three,
                     i_ext_mem_clock_in};
        sync_two <= sync_one;
    end

    assign ext_level   = sync_two[0];
    assign int_level   = sync_two[1];
    assign sel_level   = sync_two[2];
    assign strap_level = sync_two[3];
    assign hold_level  = sync_two[4];
    assign trst_level  = sync_two[5];
    assign emulation_pin_zero_level  = sync_two[6];
    assign emu1_level  = sync_two[7];

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // Straps follow the pins while reset is low and freeze at release.
    reg source_select;
    reg function_strap;

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            source_select  <= sel_level;
            function_strap <= strap_level;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    reg  [1:0] primary_mode;
    reg        primary_hold_tri;
    reg  [1:0] divided_factor;
    reg  [1:0] divided_mode;
    reg        divided_hold_tri;
    reg        primary_boot_ext;
    wire       wr_ctl1;
    wire       wr_ctl2;

    // Write strobe aimed at one register offset
    function write_hit;
        input                      strobe;
        input [`MEMCLK_ADDR_W-1:0] addr;
        input [`MEMCLK_ADDR_W-1:0] ofs;
        begin
            write_hit = strobe && (addr == ofs);
        end
    endfunction

    assign wr_ctl1 = write_hit(i_wstrobe, i_addr, `OFS_GLOBAL_CONTROL_ONE);
    assign wr_ctl2 = write_hit(i_wstrobe, i_addr, `OFS_GLOBAL_CONTROL_TWO);

    // Mode reset values come from the straps so the first cycle after release
    // already shows the boot behaviour.
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            primary_hold_tri <= `HOLD_TRI_RESET;
            divided_hold_tri <= `HOLD_TRI_RESET;
            divided_factor   <= `FACTOR_DIV4;
            primary_boot_ext <= 1'b1;
            if (!strap_level && !sel_level) begin
                primary_mode <= `MODE_HIZ;
                divided_mode <= `MODE_LOW;
            end else begin
                primary_mode <= `MODE_RUN;
                divided_mode <= `MODE_RUN;
            end
        end else begin
            if (wr_ctl1) begin
                primary_mode     <= i_wdata[`CTL1_MODE_LSB +: 2];
                primary_hold_tri <= i_wdata[`CTL1_HOLD_TRI_BIT];
                primary_boot_ext <= 1'b0;
            end
            if (wr_ctl2) begin
                divided_factor   <= i_wdata[`CTL2_FACTOR_LSB +: 2];
                divided_mode     <= i_wdata[`CTL2_MODE_LSB +: 2];
                divided_hold_tri <= i_wdata[`CTL2_HOLD_TRI_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Clock source and output generation
    // ------------------------------------------------------------------
    // Straps are live during reset so the divided output already follows
    // the pin-selected source there.
    wire       sel_now;
    wire       selected_level;
    wire       primary_src;
    wire [1:0] primary_req_mode;
    wire [1:0] divided_req_factor;
    wire [1:0] divided_req_mode;
    wire       primary_div_clk;
    wire       primary_div_oe;
    wire       divided_div_clk;
    wire       divided_div_oe;

    assign sel_now        = i_resetn ? source_select : sel_level;
    assign selected_level = sel_now ? ext_level : int_level;
    // Boot phase forwards the external clock until software rewrites the
    // primary control; the source swap at that write is not phase aligned.
    assign primary_src    = primary_boot_ext ? ext_level : selected_level;

    assign primary_req_mode   = i_resetn ? primary_mode : `MODE_HIZ;
    assign divided_req_factor = i_resetn ? divided_factor : `FACTOR_DIV4;
    assign divided_req_mode   = i_resetn ? divided_mode : `MODE_RUN;

    clock_gate_divider u_primary (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_src_level (primary_src),
        .i_factor    (`FACTOR_DIV1),
        .i_mode      (primary_req_mode),
        .o_clk       (primary_div_clk),
        .o_oe        (primary_div_oe)
    );

    clock_gate_divider u_divided (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_src_level (selected_level),
        .i_factor    (divided_req_factor),
        .i_mode      (divided_req_mode),
        .o_clk       (divided_div_clk),
        .o_oe        (divided_div_oe)
    );

    // ------------------------------------------------------------------
    // Hold and off mode
    // ------------------------------------------------------------------
    wire hold_active;
    wire off_mode;
    wire primary_oe_next;
    wire divided_oe_next;

    assign hold_active = i_resetn && function_strap && hold_level;
    assign off_mode    = !trst_level && emulation_pin_zero_level && !emu1_level;

    // Same drive rule for both pins: off mode or a tristating hold wins
    function keep_driving;
        input div_oe;
        input tri_in_hold;
        input off;
        input hold;
        begin
            keep_driving = div_oe && !off && !(hold && tri_in_hold);
        end
    endfunction

    // Disabling the driver needs no clock alignment, so these act at once.
    assign primary_oe_next = i_resetn
                             && keep_driving(primary_div_oe, primary_hold_tri,
                                             off_mode, hold_active);
    assign divided_oe_next = keep_driving(divided_div_oe, divided_hold_tri,
                                          off_mode, hold_active);

    // ------------------------------------------------------------------
    // Re-enable alignment
    // ------------------------------------------------------------------
    // A driver that comes back from hold or off mode inside a high phase
    // would start with a runt, so the value waits for a low phase first.
    // Limitation: the first cycle after re-enable is always low.
    reg primary_armed;
    reg divided_armed;

    always @(posedge i_clk) begin
        primary_armed <= primary_oe_next && (primary_armed || !primary_div_clk);
        divided_armed <= divided_oe_next && (divided_armed || !divided_div_clk);
    end

    always @(posedge i_clk) begin
        o_mem_clock_out_primary    <= primary_div_clk & primary_oe_next & primary_armed;
        o_mem_clock_out_primary_oe <= primary_oe_next;
        o_mem_clock_out_divided    <= divided_div_clk & divided_oe_next & divided_armed;
        o_mem_clock_out_divided_oe <= divided_oe_next;
    end

    // ------------------------------------------------------------------
    // Hold acknowledge and pin function
    // ------------------------------------------------------------------
    // Acknowledge is registered from hold_active like the clock pin enables,
    // so pins set to go off in hold are released in the same cycle.
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_bus_hold_acknowledge    <= 1'b0;
            o_bus_hold_acknowledge_oe <= 1'b0;
            o_mem_function_enable     <= 1'b0;
        end else begin
            o_bus_hold_acknowledge    <= hold_active;
            o_bus_hold_acknowledge_oe <= function_strap;
            o_mem_function_enable     <= function_strap;
        end
    end

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------
    reg [`MEMCLK_DATA_W-1:0] next_rdata;

    always @* begin
        next_rdata = `RDATA_RESET;
        case (i_addr)
            `OFS_GLOBAL_CONTROL_ONE: begin
                next_rdata[`CTL1_MODE_LSB +: 2]  = primary_mode;
                next_rdata[`CTL1_HOLD_TRI_BIT]   = primary_hold_tri;
            end
            `OFS_GLOBAL_CONTROL_TWO: begin
                next_rdata[`CTL2_FACTOR_LSB +: 2] = divided_factor;
                next_rdata[`CTL2_MODE_LSB +: 2]   = divided_mode;
                next_rdata[`CTL2_HOLD_TRI_BIT]    = divided_hold_tri;
            end
            `OFS_CLOCK_STATUS: begin
                next_rdata[`STAT_SOURCE_BIT] = source_select;
                next_rdata[`STAT_STRAP_BIT]  = function_strap;
                next_rdata[`STAT_HOLD_BIT]   = hold_active;
                next_rdata[`STAT_OFF_BIT]    = off_mode;
                next_rdata[`STAT_ACK_BIT]    = o_bus_hold_acknowledge;
                next_rdata[`STAT_PRI_OE_BIT] = o_mem_clock_out_primary_oe;
                next_rdata[`STAT_DIV_OE_BIT] = o_mem_clock_out_divided_oe;
            end
            default: next_rdata = `RDATA_RESET;
        endcase
    end

    always @(posedge i_clk) begin
        if (!i_resetn)
            o_rdata <= `RDATA_RESET;
        else if (i_rstrobe)
            o_rdata <= next_rdata;
        else
            o_rdata <= `RDATA_RESET;
    end
endmodule

`default_nettype wire

// ### dv/memclk_outputs_assertions.sv
/*
 * Checker for the memory clock output block: reset, off, hold and
 * glitch-free behaviour seen at the top module's ports.
 * Assumes it is bound into memclk_outputs with name-matched ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "memclk_consts.vh"

module memclk_outputs_checker (
    input wire logic                      i_clk,
    input wire logic                      i_resetn,
    input wire logic                      i_bus_hold_request,
    input wire logic                      i_test_resetn,
    input wire logic                      i_emulation_pin_zero,
    input wire logic                      i_emulation_pin_one_off,
    input wire logic                      i_rstrobe,
    input wire logic [`MEMCLK_DATA_W-1:0] o_rdata,
    input wire logic                      o_mem_clock_out_primary,
    input wire logic                      o_mem_clock_out_primary_oe,
    input wire logic                      o_mem_clock_out_divided,
    input wire logic                      o_mem_clock_out_divided_oe,
    input wire logic                      o_bus_hold_acknowledge,
    input wire logic                      o_bus_hold_acknowledge_oe,
    input wire logic                      o_mem_function_enable
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    wire off_mode = !i_test_resetn && i_emulation_pin_zero && !i_emulation_pin_one_off;

    a_reset_out_states: assert property ($rose(i_resetn) && !$past(off_mode) |->
        !$past(o_mem_clock_out_primary_oe) && $past(o_mem_clock_out_divided_oe))
        else $error("clock output enables wrong during reset");
    a_off_mode_hiz: assert property (off_mode[*5] |->
        !o_mem_clock_out_primary_oe && !o_mem_clock_out_divided_oe)
        else $error("clock outputs driven in off mode");
    a_primary_zero_hiz: assert property (!o_mem_clock_out_primary_oe |->
        !o_mem_clock_out_primary) else $error("primary value not zero while off");
    a_divided_zero_hiz: assert property (!o_mem_clock_out_divided_oe |->
        !o_mem_clock_out_divided) else $error("divided value not zero while off");
    // A short high or low phase on the divided pin would be a runt clock
    a_divided_high_width: assert property ($rose(o_mem_clock_out_divided) |->
        (o_mem_clock_out_divided || !o_mem_clock_out_divided_oe)[*3])
        else $error("runt high pulse on divided clock");
    a_divided_low_width: assert property ($fell(o_mem_clock_out_divided) &&
        o_mem_clock_out_divided_oe |-> (!o_mem_clock_out_divided)[*3])
        else $error("runt low pulse on divided clock");
    a_rdata_idle_zero: assert property (!$past(i_rstrobe) |-> o_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_hold_ack_cause: assert property ($rose(o_bus_hold_acknowledge) |->
        $past(i_bus_hold_request, 2) && o_mem_function_enable)
        else $error("acknowledge without hold request");
    a_hold_ack_drop: assert property ((!i_bus_hold_request)[*5] |->
        !o_bus_hold_acknowledge) else $error("acknowledge stays after request drop");
    a_ack_pin_function: assert property (o_bus_hold_acknowledge_oe |->
        o_mem_function_enable) else $error("acknowledge driven without memory function");
    a_function_frozen: assert property ($past(i_resetn) && $past(i_resetn, 2) |->
        $stable(o_mem_function_enable)) else $error("memory function changed out of reset");

    c_hold_ack: cover property ($rose(o_bus_hold_acknowledge));
    c_off_mode: cover property (off_mode[*5]);
    c_reset_release: cover property ($rose(i_resetn));
    c_divided_rise: cover property ($rose(o_mem_clock_out_divided));
endmodule

`default_nettype wire

// ### dv/mem_clock_source.sv
/*
 * Free-running clock source standing in for the external memory clock pin
 * and for the internal system clock.
 * Assumes the half period is several i_clk periods so sampling sees it.
 */
`timescale 1ns/1ps
`default_nettype none

module mem_clock_source #(
    parameter int HALF_NS = 400,
    parameter int LAG_NS  = 37
) (
    output var logic o_clk
);
    // Lag keeps source edges away from i_clk edges, so sampling is clean
    initial begin
        o_clk = 1'b0;
        #(LAG_NS);
        forever begin
            #(HALF_NS) o_clk = ~o_clk;
        end
    end
endmodule

`default_nettype wire

// ### dv/memclk_outputs_test.sv
/*
 * Self-checking bench for memclk_outputs: boot straps, control registers,
 * bus hold and off mode, judged by counting clock rises over 96 cycles.
 * Assumes external period 8 and internal period 12 i_clk cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module memclk_outputs_test;
    logic        i_clk, i_resetn, ext_clk, int_clk, sel, strap, hold;
    logic        trst_n, emulation_pin_zero, emu1, i_wstrobe, i_rstrobe;
    logic        pri, pri_oe, dv, dv_oe, ack, ack_oe, fen;
    logic [3:0]  i_addr;
    logic [15:0] i_wdata, o_rdata;
    int          num_errors, total_checks;

    mem_clock_source #(.HALF_NS(400), .LAG_NS(37)) ext_u (.o_clk(ext_clk));
    mem_clock_source #(.HALF_NS(600), .LAG_NS(71)) int_u (.o_clk(int_clk));

    memclk_outputs dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_ext_mem_clock_in(ext_clk),
        .i_internal_system_clock_three(int_clk), .i_mem_clock_source_select(sel),
        .i_boot_function_strap(strap), .i_bus_hold_request(hold), .i_test_resetn(trst_n),
        .i_emulation_pin_zero(emulation_pin_zero), .i_emulation_pin_one_off(emu1), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wstrobe(i_wstrobe), .i_rstrobe(i_rstrobe), .o_rdata(o_rdata),
        .o_mem_clock_out_primary(pri), .o_mem_clock_out_primary_oe(pri_oe),
        .o_mem_clock_out_divided(dv), .o_mem_clock_out_divided_oe(dv_oe),
        .o_bus_hold_acknowledge(ack), .o_bus_hold_acknowledge_oe(ack_oe),
        .o_mem_function_enable(fen));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wstrobe <= 1'b1;
        i_addr    <= a;
        i_wdata   <= d;
        @(posedge i_clk);
        i_wstrobe <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_rstrobe <= 1'b1;
        i_addr    <= a;
        @(posedge i_clk);
        i_rstrobe <= 1'b0;
        #1 d = o_rdata;
    endtask

    // Window of 96 cycles holds a whole number of every expected period
    task automatic meas(input logic [15:0] ep, input logic [15:0] ed, input logic po,
                        input logic dn);
        int   np, nd;
        logic lp, ld;
        np = 0;
        nd = 0;
        @(posedge i_clk);
        #1 lp = pri;
        ld = dv;
        repeat (96) begin
            @(posedge i_clk);
            #1 np += int'(pri && !lp);
            nd += int'(dv && !ld);
            lp = pri;
            ld = dv;
        end
        chk(16'(np), ep);
        chk(16'(nd), ed);
        chk({15'h0, pri_oe}, {15'h0, po});
        chk({15'h0, dv_oe}, {15'h0, dn});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic boot_case(input logic s, input logic c);
        @(posedge i_clk);
        i_resetn <= 1'b0;
        strap    <= s;
        sel      <= c;
        cyc(40);
        meas(16'h0, c ? 16'h3 : 16'h2, 1'b0, 1'b1);
        @(posedge i_clk);
        i_resetn <= 1'b1;
        cyc(64);
        meas((s | c) ? 16'hC : 16'h0, c ? 16'h3 : (s ? 16'h2 : 16'h0), s | c, 1'b1);
        chk({15'h0, fen}, {15'h0, s});
        chk({15'h0, ack_oe}, {15'h0, s});
    endtask

    task automatic ctl_case();
        logic [15:0] d;
        for (int m = 0; m < 4; m++) begin
            wr(4'h0, 16'(m));
            wr(4'h1, 16'(m * 4 + 1));
            cyc(64);
            meas(m == 0 ? 16'h8 : 16'h0, m == 0 ? 16'h4 : 16'h0, m < 2, m < 2);
        end
        for (int f = 0; f < 4; f++) begin
            wr(4'h1, 16'(f));
            cyc(64);
            meas(16'h0, 16'h8 >> (f == 3 ? 2 : f), 1'b0, 1'b1);
        end
        @(posedge i_clk);
        sel <= 1'b1;
        cyc(64);
        meas(16'h0, 16'h2, 1'b0, 1'b1);
        @(posedge i_clk);
        sel <= 1'b0;
        wr(4'h2, 16'hFFFF);
        rd(4'h2, d);
        chk(d & 16'h0003, 16'h0002);
        rd(4'h7, d);
        chk(d, 16'h0000);
    endtask

    task automatic hold_case();
        logic [15:0] d;
        int          n;
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h0010);
        rd(4'h1, d);
        chk(d & 16'h001F, 16'h0010);
        cyc(64);
        @(posedge i_clk);
        hold <= 1'b1;
        n = 0;
        while (ack !== 1'b1 && n < 16) begin
            @(posedge i_clk) #1;
            n++;
        end
        if (n == 16) begin
            num_errors++;
            end_sim();
        end
        meas(16'h8, 16'h0, 1'b1, 1'b0);
        @(posedge i_clk);
        hold <= 1'b0;
        cyc(8);
        chk({15'h0, ack}, 16'h0000);
        cyc(64);
        meas(16'h8, 16'h8, 1'b1, 1'b1);
        wr(4'h0, 16'h0004);
        wr(4'h1, 16'h0000);
        @(posedge i_clk);
        hold <= 1'b1;
        cyc(8);
        meas(16'h0, 16'h8, 1'b0, 1'b1);
        @(posedge i_clk);
        hold <= 1'b0;
        cyc(8);
    endtask

    task automatic off_case();
        @(posedge i_clk);
        trst_n <= 1'b0;
        emulation_pin_zero   <= 1'b1;
        cyc(8);
        meas(16'h8, 16'h8, 1'b1, 1'b1);
        @(posedge i_clk);
        emu1 <= 1'b0;
        cyc(8);
        meas(16'h0, 16'h0, 1'b0, 1'b0);
    endtask

    initial begin
        i_clk = 1'b0;
        forever begin
            #50 i_clk = ~i_clk;
        end
    end

    initial begin
        {i_resetn, sel, strap, hold, emulation_pin_zero, i_wstrobe, i_rstrobe} = 7'h00;
        {trst_n, emu1} = 2'h3;
        i_addr = 4'h0;
        i_wdata = 16'h0000;
        num_errors = 0;
        total_checks = 0;
        cyc(3);
        boot_case(1'b0, 1'b0);
        boot_case(1'b0, 1'b1);
        boot_case(1'b1, 1'b1);
        boot_case(1'b1, 1'b0);
        ctl_case();
        hold_case();
        off_case();
        end_sim();
    end
endmodule

bind memclk_outputs memclk_outputs_checker chk_u (.*);

`default_nettype wire
